// >>> include/cmb_consts.svh
// constants of the message-object mailbox: offsets, fields, resets, timing
// assumes inclusion by the package, design and bench files of the mailbox only
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH
`define CMB_NOBJ 6
`define CMB_OFS_PAGE 8'h00
`define CMB_OFS_STAT 8'h01
`define CMB_OFS_CFG 8'h02
`define CMB_OFS_IDT0 8'h03
`define CMB_OFS_IDT3 8'h06
`define CMB_OFS_IDM0 8'h07
`define CMB_OFS_IDM3 8'h0A
`define CMB_OFS_MSG 8'h0B
`define CMB_OFS_STPL 8'h0C
`define CMB_OFS_STPH 8'h0D
`define CMB_OFS_GCON 8'h10
`define CMB_OFS_GSTA 8'h11
`define CMB_OFS_GIT 8'h12
`define CMB_OFS_IE 8'h13
`define CMB_OFS_SIT 8'h14
`define CMB_OFS_HPOB 8'h15
`define CMB_OFS_PRE 8'h16
`define CMB_OFS_TIML 8'h17
`define CMB_OFS_TIMH 8'h18
`define CMB_OFS_CAPL 8'h19
`define CMB_OFS_CAPH 8'h1A
`define CMB_ST_TX 6
`define CMB_ST_RX 5
`define CMB_ST_ERR 0
`define CMB_GIT_OVR 0
`define CMB_GIT_BX 1
`define CMB_HP_NONE 4'h_F
`define CMB_RST_BYTE 8'h_00
`define CMB_TIM_DIV 3'h_7
`endif

// >>> include/cmb_pkg.sv
// types and helpers of the message-object mailbox
// assumes cmb_consts.svh on the include path
`include "cmb_consts.svh"
package cmb_pkg;
	typedef enum logic [1:0] {CMB_DIS = 2'h_0, CMB_TX = 2'h_1, CMB_RX = 2'h_2, CMB_FB = 2'h_3}
		cmb_cfg_t;
	// lowest set bit wins; none gives the empty code
	function automatic logic [3:0] cmb_first(input logic [`CMB_NOBJ-1:0] v);
		logic [3:0] r;
		r = `CMB_HP_NONE;
		for (int i = `CMB_NOBJ - 1; i >= 0; i--)
			if (v[i])
				r = 4'(i);
		return r;
	endfunction : cmb_first
endpackage : cmb_pkg

// >>> include/cmb_tmr_if.sv
// link between the mailbox and its stamping timer
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface cmb_tmr_if;
	logic en;
	logic [7:0] presc;
	logic [15:0] count;
	logic ovf;
	modport tmr (input en, input presc, output count, output ovf);
	modport user (output en, output presc, input count, input ovf);
endinterface : cmb_tmr_if
`default_nettype wire

// >>> core/cmb_timer.sv
// stamping timer: clock divided by 8, then by prescale plus one, 16-bit count
// assumes clk_sys and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cmb_timer
	import cmb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	cmb_tmr_if.tmr t
);
	logic [2:0] div;
	logic [7:0] pre;
	logic [15:0] cnt;
	logic ovf;
	logic [2:0] next_div;
	logic [7:0] next_pre;
	logic [15:0] next_cnt;
	logic next_ovf;

	always_comb
	begin
		next_div = div;
		next_pre = pre;
		next_cnt = cnt;
		next_ovf = 1'b0;
		if (!t.en)
		begin
			// held at zero so counting restarts from zero on enable
			next_div = 3'h_0;
			next_pre = 8'h_00;
			next_cnt = 16'h_0000;
		end
		else if (div == `CMB_TIM_DIV)
		begin
			next_div = 3'h_0;
			if (pre >= t.presc)
			begin
				next_pre = 8'h_00;
				next_cnt = 16'(cnt + 16'h_0001);
				next_ovf = (cnt == 16'h_FFFF);
			end
			else
				next_pre = 8'(pre + 8'h_01);
		end
		else
			next_div = 3'(div + 3'h_1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			div <= 3'h_0;
			pre <= 8'h_00;
			cnt <= 16'h_0000;
			ovf <= 1'b0;
		end
		else
		begin
			div <= next_div;
			pre <= next_pre;
			cnt <= next_cnt;
			ovf <= next_ovf;
		end
	end

	assign t.count = cnt;
	assign t.ovf = ovf;
endmodule : cmb_timer
`default_nettype wire

// >>> core/cmb_mailbox.sv
// message-object mailbox: six objects, filter, priority scan, data buffers
// assumes a bit engine on clk_sys giving one-cycle frame strobes
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"
// Summary of operation
// - six objects numbered zero to five
// - lowest numbered object wins on multiple match
// - two-bit field selects object mode
// - scan transmit objects, send highest priority
// - sent frame sets transmit-complete flag
// - received identifier picks best matching receiver
// - hit overwrites identifier, extension, length
// - byte strobes store data, completion sets receive flag
// - remote match on reply object sends reply
// - buffer flag after whole buffer set received
// - buffer flag clears only after configs rewritten
// - masked compare, received tags overwrite stored
// - page register selects one object
// - top priority register encodes pending objects
// - byte index auto-increments and wraps seven
// - first data byte lands at index zero
// - tick is clock/8/(prescale+1) while enabled
// - timer restarts at enable, flags overrun
// - sync select picks start or end capture
// - time-triggered frames never retried
// - completion flag copies timer into stamp
module cmb_mailbox
	import cmb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic tx_pending,
	output logic [2:0] tx_obj,
	output logic [28:0] tx_id,
	output logic tx_ide,
	output logic tx_rtr,
	output logic [1:0] tx_rb,
	output logic [3:0] tx_dlc,
	output logic tx_single_shot,
	input wire logic tx_start,
	input wire logic [2:0] tx_byte_idx,
	output logic [7:0] tx_byte,
	input wire logic tx_done,
	input wire logic tx_error,
	input wire logic rx_id_strobe,
	input wire logic [28:0] rx_id,
	input wire logic rx_ide,
	input wire logic rx_rtr,
	input wire logic [1:0] rx_rb,
	input wire logic [3:0] rx_dlc,
	output logic rx_hit,
	input wire logic rx_byte_strobe,
	input wire logic [7:0] rx_byte,
	input wire logic rx_done,
	input wire logic rx_error,
	input wire logic frame_sof,
	input wire logic frame_eof
);
	localparam int N = `CMB_NOBJ;
	// ------------------------------------------------------------
	// object and global state
	// ------------------------------------------------------------
	cmb_cfg_t cfg [N];
	logic [28:0] identifier_tag [N];
	logic [28:0] idm [N];
	logic [1:0] rbt [N];
	logic [3:0] dlc [N];
	logic [15:0] stamp [N];
	logic [7:0] dat [N][8];
	logic [N-1:0] ide, rtr, reply_valid_bit, ide_m, rtr_m, f_tx, f_rx, f_err, fb_full;
	logic [N-1:0] bx_set, rewr;
	logic [3:0] page;
	logic aincd, en, time_triggered_mode, syncsel, ovr, buffer_complete_flag, fb_all_q, tx_act, rx_remote;
	logic [2:0] idx, rx_wi, hit_obj, tx_cur, ie;
	logic [7:0] presc;
	logic [15:0] ttc_cap;
	cmb_cfg_t next_cfg [N];
	logic [28:0] next_idt [N];
	logic [28:0] next_idm [N];
	logic [1:0] next_rbt [N];
	logic [3:0] next_dlc [N];
	logic [15:0] next_stamp [N];
	logic [7:0] next_dat [N][8];
	logic [N-1:0] next_ide, next_rtr, next_reply_valid_bit, next_ide_m, next_rtr_m;
	logic [N-1:0] next_f_tx, next_f_rx, next_f_err, next_fb_full, next_bx_set, next_rewr;
	logic [3:0] next_page;
	logic next_aincd, next_en, next_ttc, next_syncsel, next_ovr, next_buffer_complete_flag;
	logic next_fb_all_q, next_tx_act, next_rx_remote, next_rx_hit;
	logic [2:0] next_idx, next_rx_wi, next_hit_obj, next_tx_cur, next_ie;
	logic [7:0] next_presc, next_rdata;
	logic [15:0] next_ttc_cap;
	// ------------------------------------------------------------
	// per-object scan terms
	// ------------------------------------------------------------
	logic [N-1:0] rx_match, tx_rdy, fb_mem, sit;
	logic [3:0] rx_first, tx_first, hp;
	logic [2:0] pg, tx_sel;
	logic pg_ok, fb_all;
	cmb_tmr_if tmr ();

	cmb_timer u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.t(tmr.tmr)
	);
	assign tmr.en = en;
	assign tmr.presc = presc;

	for (genvar i = 0; i < N; i++)
	begin : g_obj
		// masked compare; reserved bits carry no mask and are not compared
		assign rx_match[i] = (cfg[i] == CMB_RX || (cfg[i] == CMB_FB && !fb_full[i]))
			&& (((rx_id ^ identifier_tag[i]) & idm[i]) == 29'h0)
			&& (!ide_m[i] || rx_ide == ide[i])
			&& (!rtr_m[i] || rx_rtr == rtr[i]);
		assign tx_rdy[i] = (cfg[i] == CMB_TX);
		assign fb_mem[i] = (cfg[i] == CMB_FB);
		assign sit[i] = (f_rx[i] & ie[0]) | (f_tx[i] & ie[1]) | (f_err[i] & ie[2]);
	end

	assign rx_first = cmb_first(rx_match);
	assign tx_first = cmb_first(tx_rdy);
	assign hp = cmb_first(sit);
	assign pg = page[2:0];
	assign pg_ok = (page < 4'(N));
	assign fb_all = (fb_mem != '0) && ((fb_mem & ~fb_full) == '0);
	assign tx_sel = tx_act ? tx_cur : tx_first[2:0];
	// ------------------------------------------------------------
	// engine side outputs
	// ------------------------------------------------------------
	assign tx_pending = en && !tx_act && (tx_rdy != '0);
	assign tx_obj = tx_sel;
	assign tx_id = identifier_tag[tx_sel];
	assign tx_ide = ide[tx_sel];
	assign tx_rtr = rtr[tx_sel];
	assign tx_rb = rbt[tx_sel];
	assign tx_dlc = dlc[tx_sel];
	assign tx_byte = dat[tx_sel][tx_byte_idx];
	assign tx_single_shot = time_triggered_mode;
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_cfg = cfg;
		next_idt = identifier_tag;
		next_idm = idm;
		next_rbt = rbt;
		next_dlc = dlc;
		next_stamp = stamp;
		next_dat = dat;
		next_ide = ide;
		next_rtr = rtr;
		next_reply_valid_bit = reply_valid_bit;
		next_ide_m = ide_m;
		next_rtr_m = rtr_m;
		next_f_tx = f_tx;
		next_f_rx = f_rx;
		next_f_err = f_err;
		next_fb_full = fb_full;
		next_bx_set = bx_set;
		next_rewr = rewr;
		next_page = page;
		next_aincd = aincd;
		next_idx = idx;
		next_en = en;
		next_ttc = time_triggered_mode;
		next_syncsel = syncsel;
		next_ovr = ovr;
		next_buffer_complete_flag = buffer_complete_flag;
		next_fb_all_q = fb_all;
		next_ie = ie;
		next_presc = presc;
		next_ttc_cap = ttc_cap;
		next_tx_act = tx_act;
		next_tx_cur = tx_cur;
		next_rx_hit = rx_hit;
		next_hit_obj = hit_obj;
		next_rx_wi = rx_wi;
		next_rx_remote = rx_remote;
		// software writes first, so hardware events below win over clears
		if (wr)
		begin
			case (addr)
				`CMB_OFS_PAGE:
				begin
					next_page = wdata[7:4];
					next_aincd = wdata[3];
					next_idx = wdata[2:0];
				end
				`CMB_OFS_GCON:
				begin
					next_en = wdata[0];
					next_ttc = wdata[1];
					next_syncsel = wdata[2];
				end
				`CMB_OFS_GIT:
				begin
					if (wdata[`CMB_GIT_OVR])
						next_ovr = 1'b0;
					if (wdata[`CMB_GIT_BX] && (bx_set & ~rewr) == '0)
						next_buffer_complete_flag = 1'b0;
				end
				`CMB_OFS_IE: next_ie = wdata[2:0];
				`CMB_OFS_PRE: next_presc = wdata;
				default: ;
			endcase
			if (pg_ok)
			begin
				case (addr)
					`CMB_OFS_STAT:
					begin
						next_f_tx[pg] = f_tx[pg] & wdata[`CMB_ST_TX];
						next_f_rx[pg] = f_rx[pg] & wdata[`CMB_ST_RX];
						next_f_err[pg] = f_err[pg] & wdata[`CMB_ST_ERR];
					end
					`CMB_OFS_CFG:
					begin
						next_cfg[pg] = cmb_cfg_t'(wdata[7:6]);
						next_ide[pg] = wdata[5];
						next_reply_valid_bit[pg] = wdata[4];
						next_dlc[pg] = wdata[3:0];
						next_fb_full[pg] = 1'b0;
						next_rewr[pg] = 1'b1;
					end
					`CMB_OFS_IDT0, 8'h04, 8'h05: next_idt[pg][8*(addr-`CMB_OFS_IDT0) +: 8] = wdata;
					`CMB_OFS_IDT3:
					begin
						next_idt[pg][28:24] = wdata[4:0];
						next_rtr[pg] = wdata[5];
						next_rbt[pg] = wdata[7:6];
					end
					`CMB_OFS_IDM0, 8'h08, 8'h09: next_idm[pg][8*(addr-`CMB_OFS_IDM0) +: 8] = wdata;
					`CMB_OFS_IDM3:
					begin
						next_idm[pg][28:24] = wdata[4:0];
						next_rtr_m[pg] = wdata[5];
						next_ide_m[pg] = wdata[6];
					end
					`CMB_OFS_MSG: next_dat[pg][idx] = wdata;
					default: ;
				endcase
			end
		end
		if ((wr || rd) && addr == `CMB_OFS_MSG && pg_ok && !aincd)
			next_idx = 3'(idx + 3'h_1);
		if (tmr.ovf)
			next_ovr = 1'b1;
		if (time_triggered_mode && ((frame_sof && !syncsel) || (frame_eof && syncsel)))
			next_ttc_cap = tmr.count;
		// transmit side
		if (tx_start && tx_pending)
		begin
			next_tx_act = 1'b1;
			next_tx_cur = tx_first[2:0];
		end
		if (tx_act && tx_done)
		begin
			next_tx_act = 1'b0;
			next_cfg[tx_cur] = CMB_DIS;
			next_f_tx[tx_cur] = 1'b1;
			next_stamp[tx_cur] = tmr.count;
		end
		else if (tx_act && tx_error)
		begin
			next_tx_act = 1'b0;
			next_f_err[tx_cur] = 1'b1;
			if (time_triggered_mode)
				next_cfg[tx_cur] = CMB_DIS;
		end
		// receive side
		if (rx_id_strobe)
		begin
			next_rx_hit = en && rx_first != `CMB_HP_NONE;
			next_hit_obj = rx_first[2:0];
			next_rx_wi = 3'h_0;
			next_rx_remote = rx_rtr;
			if (en && rx_first != `CMB_HP_NONE)
			begin
				next_idt[rx_first[2:0]] = rx_id;
				next_ide[rx_first[2:0]] = rx_ide;
				next_rtr[rx_first[2:0]] = rx_rtr;
				next_rbt[rx_first[2:0]] = rx_rb;
				next_dlc[rx_first[2:0]] = rx_dlc;
			end
		end
		else if (rx_hit && rx_byte_strobe && !rx_remote)
		begin
			next_dat[hit_obj][rx_wi] = rx_byte;
			next_rx_wi = 3'(rx_wi + 3'h_1);
		end
		else if (rx_hit && rx_error)
		begin
			next_rx_hit = 1'b0;
			next_f_err[hit_obj] = 1'b1;
		end
		else if (rx_hit && rx_done)
		begin
			next_rx_hit = 1'b0;
			if (rx_remote && cfg[hit_obj] == CMB_RX && reply_valid_bit[hit_obj])
			begin
				// reply: no flag now, the object turns transmitter as received
				next_rtr[hit_obj] = 1'b0;
				next_reply_valid_bit[hit_obj] = 1'b0;
				next_cfg[hit_obj] = CMB_TX;
			end
			else
			begin
				next_f_rx[hit_obj] = 1'b1;
				next_stamp[hit_obj] = tmr.count;
				if (cfg[hit_obj] == CMB_FB)
					next_fb_full[hit_obj] = 1'b1;
				else
					next_cfg[hit_obj] = CMB_DIS;
			end
		end
		if (fb_all && !fb_all_q)
		begin
			next_buffer_complete_flag = 1'b1;
			next_bx_set = fb_mem;
			next_rewr = '0;
		end
	end
	// ------------------------------------------------------------
	// read data, one cycle after the strobe
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = `CMB_RST_BYTE;
		case (addr)
			`CMB_OFS_PAGE: next_rdata = {page, aincd, idx};
			`CMB_OFS_GCON: next_rdata = {5'h_00, syncsel, time_triggered_mode, en};
			`CMB_OFS_GSTA: next_rdata = {5'h_00, en, 2'h_0};
			`CMB_OFS_GIT: next_rdata = {6'h_00, buffer_complete_flag, ovr};
			`CMB_OFS_IE: next_rdata = {5'h_00, ie};
			`CMB_OFS_SIT: next_rdata = {2'h_0, sit};
			`CMB_OFS_HPOB: next_rdata = {hp, 4'h_0};
			`CMB_OFS_PRE: next_rdata = presc;
			`CMB_OFS_TIML: next_rdata = tmr.count[7:0];
			`CMB_OFS_TIMH: next_rdata = tmr.count[15:8];
			`CMB_OFS_CAPL: next_rdata = ttc_cap[7:0];
			`CMB_OFS_CAPH: next_rdata = ttc_cap[15:8];
			default: ;
		endcase
		if (pg_ok)
		begin
			case (addr)
				`CMB_OFS_STAT: next_rdata = {1'b0, f_tx[pg], f_rx[pg], 4'h_0, f_err[pg]};
				`CMB_OFS_CFG: next_rdata = {cfg[pg], ide[pg], reply_valid_bit[pg], dlc[pg]};
				`CMB_OFS_IDT0, 8'h04, 8'h05: next_rdata = identifier_tag[pg][8*(addr-`CMB_OFS_IDT0) +: 8];
				`CMB_OFS_IDT3: next_rdata = {rbt[pg], rtr[pg], identifier_tag[pg][28:24]};
				`CMB_OFS_IDM0, 8'h08, 8'h09: next_rdata = idm[pg][8*(addr-`CMB_OFS_IDM0) +: 8];
				`CMB_OFS_IDM3: next_rdata = {1'b0, ide_m[pg], rtr_m[pg], idm[pg][28:24]};
				`CMB_OFS_MSG: next_rdata = dat[pg][idx];
				`CMB_OFS_STPL: next_rdata = stamp[pg][7:0];
				`CMB_OFS_STPH: next_rdata = stamp[pg][15:8];
				default: ;
			endcase
		end
		if (!rd)
			next_rdata = `CMB_RST_BYTE;
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < N; i++)
			begin
				cfg[i] <= CMB_DIS;
				identifier_tag[i] <= 29'h0;
				idm[i] <= 29'h0;
				rbt[i] <= 2'h_0;
				dlc[i] <= 4'h_0;
				stamp[i] <= 16'h_0000;
				for (int j = 0; j < 8; j++)
					dat[i][j] <= `CMB_RST_BYTE;
			end
			{ide, rtr, reply_valid_bit, ide_m, rtr_m} <= '0;
			{f_tx, f_rx, f_err, fb_full, bx_set, rewr} <= '0;
			page <= 4'h_0;
			{aincd, en, time_triggered_mode, syncsel, ovr, buffer_complete_flag, fb_all_q, tx_act, rx_remote, rx_hit} <= '0;
			{idx, rx_wi, hit_obj, tx_cur, ie} <= '0;
			presc <= `CMB_RST_BYTE;
			ttc_cap <= 16'h_0000;
			rdata <= `CMB_RST_BYTE;
		end
		else
		begin
			cfg <= next_cfg;
			identifier_tag <= next_idt;
			idm <= next_idm;
			rbt <= next_rbt;
			dlc <= next_dlc;
			stamp <= next_stamp;
			dat <= next_dat;
			{ide, rtr, reply_valid_bit, ide_m, rtr_m} <= {next_ide, next_rtr, next_reply_valid_bit, next_ide_m, next_rtr_m};
			{f_tx, f_rx, f_err} <= {next_f_tx, next_f_rx, next_f_err};
			{fb_full, bx_set, rewr} <= {next_fb_full, next_bx_set, next_rewr};
			page <= next_page;
			{aincd, en, time_triggered_mode, syncsel} <= {next_aincd, next_en, next_ttc, next_syncsel};
			{ovr, buffer_complete_flag, fb_all_q, tx_act} <= {next_ovr, next_buffer_complete_flag, next_fb_all_q, next_tx_act};
			{rx_remote, rx_hit} <= {next_rx_remote, next_rx_hit};
			{idx, rx_wi, hit_obj, tx_cur, ie} <= {next_idx, next_rx_wi, next_hit_obj, next_tx_cur, next_ie};
			presc <= next_presc;
			ttc_cap <= next_ttc_cap;
			rdata <= next_rdata;
		end
	end
endmodule : cmb_mailbox
`default_nettype wire

// >>> tb/cmb_mailbox_checker.sv
// port checker of the mailbox: register bus, transmit lock, receive hit
// assumes binding onto cmb_mailbox on one clock
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"
module cmb_mailbox_checker
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic tx_pending,
	input wire logic [2:0] tx_obj,
	input wire logic tx_single_shot,
	input wire logic tx_start,
	input wire logic rx_id_strobe,
	input wire logic rx_hit,
	input wire logic rx_done,
	input wire logic rx_error
);
	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_ttc; wr && addr == `CMB_OFS_GCON |=> tx_single_shot == $past(wdata[1]); endproperty
	a_ttc: assert property (p_ttc) else $error("single shot not following mode");
	property p_tx_off; wr && addr == `CMB_OFS_GCON && !wdata[0] |=> !tx_pending; endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmit pending while off");
	property p_tx_obj; tx_pending |-> tx_obj <= 3'h5; endproperty
	a_tx_obj: assert property (p_tx_obj) else $error("object number out of range");
	property p_tx_take; tx_start && tx_pending |=> !tx_pending; endproperty
	a_tx_take: assert property (p_tx_take) else $error("pending after start");
	property p_tx_lock; tx_start && tx_pending |=> $stable(tx_obj) [*8]; endproperty
	a_tx_lock: assert property (p_tx_lock) else $error("locked object moved");
	property p_hit_cause; $rose(rx_hit) |-> $past(rx_id_strobe); endproperty
	a_hit_cause: assert property (p_hit_cause) else $error("hit without identifier");
	property p_hit_hold; rx_hit && !rx_done && !rx_error |=> rx_hit; endproperty
	a_hit_hold: assert property (p_hit_hold) else $error("hit dropped early");
	property p_hit_end; rx_hit && (rx_done || rx_error) |=> !rx_hit; endproperty
	a_hit_end: assert property (p_hit_end) else $error("hit kept after end");
	c_tx: cover property (tx_start && tx_pending);
	c_hit: cover property ($rose(rx_hit));
	c_end: cover property (rx_hit && rx_done);
endmodule : cmb_mailbox_checker
bind cmb_mailbox cmb_mailbox_checker chk (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata,
	.tx_pending, .tx_obj, .tx_single_shot, .tx_start, .rx_id_strobe, .rx_hit, .rx_done, .rx_error);
`default_nettype wire

// >>> tb/cmb_engine_model.sv
// far-side model: bit engine sending pending objects and delivering frames
// assumes one-cycle strobes on clk_sys
`timescale 1ns/1ps
`default_nettype none
module cmb_engine_model
(
	input wire logic clk_sys,
	input wire logic tx_pending,
	input wire logic [2:0] tx_obj,
	input wire logic [7:0] tx_byte,
	output logic tx_start,
	output logic [2:0] tx_byte_idx,
	output logic tx_done,
	output logic tx_error,
	output logic rx_id_strobe,
	output logic [28:0] rx_id,
	output logic rx_ide,
	output logic rx_rtr,
	output logic [1:0] rx_rb,
	output logic [3:0] rx_dlc,
	output logic rx_byte_strobe,
	output logic [7:0] rx_byte,
	output logic rx_done,
	output logic rx_error,
	output logic frame_sof,
	output logic frame_eof
);
	// ------------------------------
	// transmit: takes a pending object, reads its eight bytes
	// ------------------------------
	int tx_count = 0;
	int lag = 0;
	bit fail_next = 1'b0;
	logic [2:0] last_obj = 3'h0;
	logic [63:0] last_data = '0;
	initial
	begin
		{tx_start, tx_byte_idx, tx_done, tx_error, rx_id_strobe, rx_id, rx_ide, rx_rtr} = '0;
		{rx_rb, rx_dlc, rx_byte_strobe, rx_byte, rx_done, rx_error, frame_sof, frame_eof} = '0;
		forever
		begin
			@(posedge clk_sys);
			repeat (lag) @(posedge clk_sys);
			if (tx_pending === 1'b1)
			begin
				{tx_start, frame_sof} <= 2'b11;
				@(posedge clk_sys);
				last_obj = tx_obj;
				{tx_start, frame_sof} <= 2'b00;
				for (int i = 0; i < 8; i++)
				begin
					tx_byte_idx <= 3'(i);
					@(negedge clk_sys);
					last_data[8*i +: 8] = tx_byte;
					@(posedge clk_sys);
				end
				// a commanded failure answers with an error instead of success
				{tx_done, tx_error, frame_eof} <= {!fail_next, fail_next, 1'b1};
				tx_count += int'(!fail_next);
				fail_next = 1'b0;
				@(posedge clk_sys);
				{tx_done, tx_error, frame_eof} <= 3'b000;
			end
		end
	end
	// released lines show the inverse of their last value
	task automatic rx_frame(input logic [28:0] id, input logic rtr, input logic [15:0] d);
		@(posedge clk_sys);
		{frame_sof, rx_id_strobe, rx_id, rx_rtr, rx_dlc} <= {2'b11, id, rtr, 4'h2};
		@(posedge clk_sys);
		{frame_sof, rx_id_strobe, rx_id} <= {2'b00, ~id};
		for (int i = 0; i < 2 && !rtr; i++)
		begin
			{rx_byte_strobe, rx_byte} <= {1'b1, d[8*i +: 8]};
			@(posedge clk_sys);
			{rx_byte_strobe, rx_byte} <= {1'b0, ~d[8*i +: 8]};
			@(posedge clk_sys);
		end
		{rx_done, frame_eof} <= 2'b11;
		@(posedge clk_sys);
		{rx_done, frame_eof} <= 2'b00;
	endtask : rx_frame
endmodule : cmb_engine_model
`default_nettype wire

// >>> tb/cmb_mailbox_tb.sv
// self-checking bench of the mailbox: register tasks, engine model on the far side
// assumes the package, interface and mailbox compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"
module cmb_mailbox_tb;
	logic clk_sys, rst, wr, rd, tx_pending, tx_ide, tx_rtr, tx_single_shot, tx_start;
	logic tx_done, tx_error, rx_id_strobe, rx_ide, rx_rtr, rx_hit, rx_byte_strobe;
	logic rx_done, rx_error, frame_sof, frame_eof;
	logic [7:0] addr, wdata, rdata, v, tx_byte, rx_byte;
	logic [2:0] tx_obj, tx_byte_idx;
	logic [28:0] tx_id, rx_id;
	logic [1:0] tx_rb, rx_rb;
	logic [3:0] tx_dlc, rx_dlc;
	int n_fail = 0;
	int cmp_count = 0;
	cmb_mailbox dut (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx_pending, .tx_obj,
		.tx_id, .tx_ide, .tx_rtr, .tx_rb, .tx_dlc, .tx_single_shot, .tx_start, .tx_byte_idx,
		.tx_byte, .tx_done, .tx_error, .rx_id_strobe, .rx_id, .rx_ide, .rx_rtr, .rx_rb, .rx_dlc,
		.rx_hit, .rx_byte_strobe, .rx_byte, .rx_done, .rx_error, .frame_sof, .frame_eof);
	cmb_engine_model eng (.clk_sys, .tx_pending, .tx_obj, .tx_byte, .tx_start, .tx_byte_idx,
		.tx_done, .tx_error, .rx_id_strobe, .rx_id, .rx_ide, .rx_rtr, .rx_rb, .rx_dlc,
		.rx_byte_strobe, .rx_byte, .rx_done, .rx_error, .frame_sof, .frame_eof);
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		{rd, addr} <= {1'b1, a};
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
		cmp(64'(v), 64'(e));
	endtask : rd_chk
	task automatic obj(input logic [2:0] p, input logic [7:0] a, input logic [7:0] d);
		wr_reg(`CMB_OFS_PAGE, {1'b0, p, 4'h0});
		wr_reg(a, d);
	endtask : obj
	task automatic fill(input logic [2:0] p, input logic [7:0] base);
		wr_reg(`CMB_OFS_PAGE, {1'b0, p, 4'h0});
		for (int i = 0; i < 8; i++)
			wr_reg(`CMB_OFS_MSG, base + 8'(i));
	endtask : fill
	task automatic wait_tx(input int n);
		for (int i = 0; i < 3000 && eng.tx_count < n; i++)
			@(posedge clk_sys);
		cmp(64'(eng.tx_count), 64'(n));
		if (eng.tx_count < n)
			print_verdict();
	endtask : wait_tx
	// ------------------------------
	// clock and sequence
	// ------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		rst = 1'b1;
		{wr, rd, addr, wdata} = '0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(`CMB_OFS_HPOB, 8'hF0);
		rd_chk(`CMB_OFS_TIML, 8'h00);
		wr_reg(8'h0F, 8'hA5);
		rd_chk(8'h0F, 8'h00);
		for (int p = 0; p < 6; p++)
			obj(3'(p), `CMB_OFS_CFG, 8'h00);
		obj(3'h6, `CMB_OFS_CFG, 8'h80);
		rd_chk(`CMB_OFS_CFG, 8'h00);
		obj(3'h5, `CMB_OFS_IDT0, 8'h5A);
		rd_chk(`CMB_OFS_IDT0, 8'h5A);
		wr_reg(`CMB_OFS_PAGE, 8'h06);
		for (int i = 0; i < 3; i++)
			wr_reg(`CMB_OFS_MSG, 8'hA0 + 8'(i));
		wr_reg(`CMB_OFS_PAGE, 8'h0E);
		rd_chk(`CMB_OFS_MSG, 8'hA0);
		rd_chk(`CMB_OFS_MSG, 8'hA0);
		wr_reg(`CMB_OFS_PAGE, 8'h07);
		rd_chk(`CMB_OFS_MSG, 8'hA1);
		rd_chk(`CMB_OFS_MSG, 8'hA2);
		fill(3'h2, 8'h20);
		wr_reg(`CMB_OFS_CFG, 8'h48);
		fill(3'h4, 8'h40);
		wr_reg(`CMB_OFS_CFG, 8'h48);
		wr_reg(`CMB_OFS_IE, 8'h07);
		wr_reg(`CMB_OFS_GCON, 8'h01);
		wait_tx(1);
		cmp(64'(eng.last_obj), 64'h2);
		cmp(eng.last_data, 64'h2726_2524_2322_2120);
		wait_tx(2);
		cmp(64'(eng.last_obj), 64'h4);
		wr_reg(`CMB_OFS_PAGE, 8'h20);
		rd_chk(`CMB_OFS_STAT, 8'h40);
		rd_chk(`CMB_OFS_HPOB, 8'h20);
		obj(3'h1, `CMB_OFS_IDT0, 8'h17);
		wr_reg(`CMB_OFS_IDT0 + 8'h01, 8'h03);
		wr_reg(`CMB_OFS_IDM0, 8'hFF);
		wr_reg(`CMB_OFS_IDM0 + 8'h01, 8'h07);
		wr_reg(`CMB_OFS_CFG, 8'h82);
		obj(3'h3, `CMB_OFS_CFG, 8'h82);
		eng.rx_frame(29'h318, 1'b0, 16'h0000);
		eng.rx_frame(29'h317, 1'b0, 16'hBBAA);
		wr_reg(`CMB_OFS_PAGE, 8'h10);
		rd_chk(`CMB_OFS_STAT, 8'h20);
		rd_chk(`CMB_OFS_MSG, 8'hAA);
		rd_chk(`CMB_OFS_MSG, 8'hBB);
		rd_chk(`CMB_OFS_HPOB, 8'h10);
		wr_reg(`CMB_OFS_PAGE, 8'h30);
		rd_chk(`CMB_OFS_IDT0, 8'h18);
		rd_chk(`CMB_OFS_IDT0 + 8'h01, 8'h03);
		fill(3'h0, 8'hC0);
		wr_reg(`CMB_OFS_IDT0, 8'h55);
		wr_reg(`CMB_OFS_IDT3, 8'h20);
		wr_reg(`CMB_OFS_IDM0, 8'hFF);
		wr_reg(`CMB_OFS_IDM0 + 8'h01, 8'h07);
		wr_reg(`CMB_OFS_IDM3, 8'h20);
		wr_reg(`CMB_OFS_CFG, 8'h92);
		eng.fail_next = 1'b1;
		eng.lag = 5;
		eng.rx_frame(29'h055, 1'b1, 16'h0000);
		wait_tx(3);
		cmp(eng.last_data, 64'hC7C6_C5C4_C3C2_C1C0);
		wr_reg(`CMB_OFS_PAGE, 8'h00);
		rd_chk(`CMB_OFS_STAT, 8'h41);
		rd_chk(`CMB_OFS_IDT3, 8'h00);
		wr_reg(`CMB_OFS_GCON, 8'h03);
		@(negedge clk_sys);
		cmp(64'(tx_single_shot), 64'h1);
		eng.fail_next = 1'b1;
		obj(3'h5, `CMB_OFS_CFG, 8'h41);
		for (int i = 0; i < 200 && eng.fail_next; i++)
			@(posedge clk_sys);
		cmp(64'(eng.fail_next), 64'h0);
		if (eng.fail_next)
			print_verdict();
		repeat (4) @(posedge clk_sys);
		cmp(64'(tx_pending), 64'h0);
		cmp(64'(eng.tx_count), 64'd3);
		rd_chk(`CMB_OFS_STAT, 8'h01);
		wr_reg(`CMB_OFS_GCON, 8'h01);
		obj(3'h4, `CMB_OFS_CFG, 8'hC2);
		obj(3'h5, `CMB_OFS_CFG, 8'hC2);
		eng.rx_frame(29'h100, 1'b0, 16'h0201);
		rd_chk(`CMB_OFS_GIT, 8'h00);
		eng.rx_frame(29'h101, 1'b0, 16'h0403);
		rd_chk(`CMB_OFS_GIT, 8'h02);
		wr_reg(`CMB_OFS_GIT, 8'h02);
		rd_chk(`CMB_OFS_GIT, 8'h02);
		obj(3'h4, `CMB_OFS_CFG, 8'hC2);
		obj(3'h5, `CMB_OFS_CFG, 8'hC2);
		wr_reg(`CMB_OFS_GIT, 8'h02);
		rd_chk(`CMB_OFS_GIT, 8'h00);
		wr_reg(`CMB_OFS_GCON, 8'h00);
		rd_chk(`CMB_OFS_TIML, 8'h00);
		wr_reg(`CMB_OFS_PRE, 8'h01);
		wr_reg(`CMB_OFS_GCON, 8'h01);
		repeat (160) @(posedge clk_sys);
		rd_chk(`CMB_OFS_TIMH, 8'h00);
		rd_chk(`CMB_OFS_TIML, 8'h0A);
		eng.rx_frame(29'h102, 1'b0, 16'h0605);
		wr_reg(`CMB_OFS_PAGE, 8'h40);
		rd_chk(`CMB_OFS_STPL, 8'h0A);
		print_verdict();
	end
endmodule : cmb_mailbox_tb
`default_nettype wire
